// File: hw/atu_pkg.sv
// Shared constants, word layouts and carrier types of the translation unit
package atu_pkg;

    // Address split of a 32-bit logical address
    localparam int ATU_LA_W = 32;
    localparam int ATU_SEG_LO = 28;
    localparam int ATU_PG_LO = 12;
    localparam int ATU_BLK_LO = 17;
    localparam int ATU_PI_W = 16;
    localparam int ATU_VSID_W = 24;
    localparam int ATU_VA_W = ATU_VSID_W + ATU_LA_W - ATU_SEG_LO + ATU_PI_W - 16;
    localparam int ATU_PPN_W = 20;
    localparam int ATU_BEPI_W = 15;
    localparam int ATU_MASK_W = 6;
    localparam int ATU_API_W = 6;
    localparam int ATU_HASH_W = 10;

    // Storage sizes
    localparam int ATU_SEG_N = 16;
    localparam int ATU_SET_W = 7;
    localparam int ATU_UB_N = 256;
    localparam int ATU_FB_N = 4;
    localparam int ATU_BX_N = 4;
    localparam int ATU_GRP_W = 3;
    localparam logic [ATU_GRP_W-1:0] ATU_GRP_LAST = 3'h7;
    localparam logic [1:0] ATU_FB_OLD = 2'h3;
    localparam logic [7:0] ATU_FB_AGE_RST = 8'hE4;
    localparam int ATU_HIT_LAT = 1;

    typedef enum logic [1:0] {K_FETCH = 2'h0, K_LOAD = 2'h1,
        K_STORE = 2'h2} atu_kind_t;

    typedef enum logic [5:0] {S_IDLE = 6'h01, S_LOOK = 6'h02, S_RD0 = 6'h04,
        S_RD1 = 6'h08, S_MARK = 6'h10, S_FILL = 6'h20} atu_state_t;

    // Word layouts: segment register, block words, page descriptor words
    typedef struct packed {logic t; logic ks; logic ku; logic [4:0] rsv;
        logic [ATU_VSID_W-1:0] vsid;} atu_seg_t;
    typedef struct packed {logic [ATU_BEPI_W-1:0] bepi; logic [10:0] rsv;
        logic [ATU_MASK_W-1:0] mask;} atu_bx_hi_t;
    typedef struct packed {logic [ATU_BEPI_W-1:0] brpn; logic [10:0] rsv;
        logic sv; logic uv; logic [1:0] rsv2; logic [1:0] pp;} atu_bx_lo_t;
    typedef struct packed {logic v; logic [ATU_VSID_W-1:0] vsid;
        logic [ATU_API_W-1:0] api; logic h;} atu_pd0_t;
    typedef struct packed {logic [ATU_PPN_W-1:0] ppn; logic [2:0] rsv;
        logic r; logic c; logic [4:0] rsv2; logic [1:0] pp;} atu_pd1_t;
    typedef struct packed {logic [15:0] base; logic [15:0] rsv;} atu_tsd_t;
    typedef struct packed {logic blk; logic hi; logic [1:0] ent;
        logic lo;} atu_spr_a_t;

    // Stored translation entries
    typedef struct packed {logic v; logic [ATU_VSID_W+8:0] tag;
        logic [ATU_PPN_W-1:0] ppn; logic [1:0] pp;} atu_ub_t;
    typedef struct packed {logic v; logic [ATU_VSID_W+ATU_PI_W-1:0] tag;
        logic [ATU_PPN_W-1:0] ppn; logic [1:0] pp;} atu_fb_t;
    typedef struct packed {atu_bx_hi_t hi; atu_bx_lo_t lo;} atu_bx_t;

    // Request and answer carriers
    typedef struct packed {logic [ATU_LA_W-1:0] la; atu_kind_t kind;
        logic sup; logic ien; logic den;} atu_req_t;
    typedef struct packed {logic valid; logic [ATU_LA_W-1:0] pa;
        logic fault; logic io;} atu_resp_t;

endpackage : atu_pkg

// File: hw/atu_top.sv
// Address translation unit: segments, block array, two buffers, table walk
`timescale 1ns/10ps
module atu_top import atu_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire atu_req_t req_in,
    output logic ready_out,
    output atu_resp_t resp_out,
    input wire logic flush_in,
    input wire atu_tsd_t table_search_descriptor_in,
    input wire logic spr_wr_in,
    input wire logic spr_sup_in,
    input wire atu_spr_a_t spr_addr_in,
    input wire logic [31:0] spr_wdata_in,
    output logic [31:0] spr_rdata_out,
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in
);

    typedef struct packed {
        atu_state_t st;
        logic ready;
        atu_req_t req;
        atu_ub_t [ATU_UB_N-1:0] ub;
        logic [ATU_UB_N/2-1:0] ub_lru;
        atu_fb_t [ATU_FB_N-1:0] fb;
        logic [ATU_FB_N-1:0][1:0] fb_age;
        atu_bx_t [ATU_BX_N-1:0] bx;
        logic [ATU_SEG_N-1:0][31:0] seg;
        logic [ATU_GRP_W-1:0] grp;
        logic [31:0] w0;
        logic [31:0] w1;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        atu_resp_t resp;
        logic [31:0] spr_rdata;
    } atu_regs_t;

    atu_regs_t r_r;
    atu_regs_t r_nxt;
    logic look_walk;
    logic look_blk;
    logic look_direct;

    // Page protection; fetches check like loads
    function automatic logic atu_denied(input logic key, input logic [1:0] pp,
                                        input logic store);
        atu_denied = (key && pp == 2'h0) ||
                     (store && (pp == 2'h3 || (key && pp == 2'h1)));
    endfunction : atu_denied

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        atu_seg_t sg;
        logic [ATU_PI_W-1:0] pi;
        logic [ATU_SET_W-1:0] set;
        logic is_fetch;
        logic is_store;
        logic xen;
        logic key;
        logic [ATU_HASH_W-1:0] hsh;
        logic bhit;
        logic [ATU_LA_W-1:0] bpa;
        logic [1:0] bpp;
        logic [ATU_BEPI_W-1:0] mk;
        logic fhit;
        logic [1:0] fidx;
        logic [1:0] fage;
        logic [1:0] fvic;
        logic uhit;
        logic uway;
        atu_ub_t ue;
        atu_pd0_t p0;
        atu_pd1_t p1;
        atu_bx_t be;
        r_nxt = r_r;
        sg = atu_seg_t'(r_r.seg[r_r.req.la[ATU_LA_W-1:ATU_SEG_LO]]);
        pi = r_r.req.la[ATU_SEG_LO-1:ATU_PG_LO];
        set = pi[ATU_SET_W-1:0];
        is_fetch = (r_r.req.kind == K_FETCH);
        is_store = (r_r.req.kind == K_STORE);
        xen = is_fetch ? r_r.req.ien : r_r.req.den;
        key = r_r.req.sup ? sg.ks : sg.ku;
        hsh = sg.vsid[ATU_HASH_W-1:0] ^ pi[ATU_HASH_W-1:0];
        bhit = 1'b0;
        bpa = r_r.req.la;
        bpp = 2'h0;
        for (int i = 0; i < ATU_BX_N; i++) begin
            be = r_r.bx[i];
            mk = ATU_BEPI_W'(be.hi.mask);
            if (!bhit && (r_r.req.sup ? be.lo.sv : be.lo.uv) &&
                ((r_r.req.la[ATU_LA_W-1:ATU_BLK_LO] & ~mk) ==
                 (be.hi.bepi & ~mk))) begin
                bhit = 1'b1;
                bpp = be.lo.pp;
                bpa[ATU_LA_W-1:ATU_BLK_LO] = (be.lo.brpn & ~mk) |
                    (r_r.req.la[ATU_LA_W-1:ATU_BLK_LO] & mk);
            end
        end
        // fetch buffer search and its oldest entry
        fhit = 1'b0;
        fidx = 2'h0;
        fvic = 2'h0;
        for (int i = 0; i < ATU_FB_N; i++) begin
            if (r_r.fb[i].v && r_r.fb[i].tag == {sg.vsid, pi}) begin
                fhit = 1'b1;
                fidx = 2'(i);
            end
            if (r_r.fb_age[i] == ATU_FB_OLD) begin
                fvic = 2'(i);
            end
        end
        fage = r_r.fb_age[fidx];
        // two-way lookup in the selected set
        uhit = 1'b0;
        uway = 1'b0;
        for (int w = 0; w < 2; w++) begin
            if (r_r.ub[{set, 1'(w)}].v &&
                r_r.ub[{set, 1'(w)}].tag ==
                {sg.vsid, pi[ATU_PI_W-1:ATU_SET_W]}) begin
                uhit = 1'b1;
                uway = 1'(w);
            end
        end
        ue = r_r.ub[{set, uway}];
        p0 = atu_pd0_t'(r_r.w0);
        p1 = atu_pd1_t'(mem_rdata_in);
        look_walk = 1'b0;
        look_blk = 1'b0;
        look_direct = 1'b0;
        r_nxt.resp.valid = 1'b0;
        // no guarded attribute exists anywhere below
        unique case (r_r.st)
            S_IDLE: begin
                if (req_valid_in) begin
                    r_nxt.req = req_in;
                    r_nxt.st = S_LOOK;
                    r_nxt.ready = 1'b0;
                end
            end
            S_LOOK: begin
                r_nxt.resp.pa = r_r.req.la;
                r_nxt.resp.fault = 1'b0;
                r_nxt.resp.io = 1'b0;
                r_nxt.st = S_IDLE;
                r_nxt.ready = 1'b1;
                r_nxt.resp.valid = 1'b1;
                // I/O segments bypass buffers even untranslated
                if (sg.t && !is_fetch) begin
                    r_nxt.resp.io = 1'b1;
                end else if (!xen) begin
                    look_direct = 1'b1;
                end else if (sg.t) begin
                    r_nxt.resp.fault = 1'b1;
                end else if (bhit) begin
                    look_blk = 1'b1;
                    r_nxt.resp.pa = bpa;
                    r_nxt.resp.fault = atu_denied(1'b0, bpp, is_store);
                end else if (is_fetch && fhit) begin
                    r_nxt.resp.pa[ATU_LA_W-1:ATU_PG_LO] = r_r.fb[fidx].ppn;
                    r_nxt.resp.fault = atu_denied(key, r_r.fb[fidx].pp,
                                                  1'b0);
                    for (int i = 0; i < ATU_FB_N; i++) begin
                        if (r_r.fb_age[i] < fage) begin
                            r_nxt.fb_age[i] = r_r.fb_age[i] + 2'h1;
                        end
                    end
                    r_nxt.fb_age[fidx] = 2'h0;
                end else if (uhit) begin
                    // frame and protection from the descriptor copy
                    r_nxt.resp.pa[ATU_LA_W-1:ATU_PG_LO] = ue.ppn;
                    r_nxt.resp.fault = atu_denied(key, ue.pp, is_store);
                    r_nxt.ub_lru[set] = ~uway;
                    if (is_fetch) begin
                        r_nxt.fb[fvic] = {1'b1, sg.vsid, pi, ue.ppn, ue.pp};
                        for (int i = 0; i < ATU_FB_N; i++) begin
                            r_nxt.fb_age[i] = r_r.fb_age[i] + 2'h1;
                        end
                        r_nxt.fb_age[fvic] = 2'h0;
                    end
                end else begin
                    look_walk = 1'b1;
                    // Last answer stands until the walk ends
                    r_nxt.resp = r_r.resp;
                    r_nxt.resp.valid = 1'b0;
                    r_nxt.ready = 1'b0;
                    r_nxt.st = S_RD0;
                    r_nxt.grp = '0;
                    r_nxt.mem_req = 1'b1;
                    r_nxt.mem_addr = {table_search_descriptor_in.base, hsh,
                                      ATU_GRP_W'(0), 3'h0};
                end
            end
            S_RD0: begin
                if (mem_ack_in) begin
                    r_nxt.w0 = mem_rdata_in;
                    r_nxt.st = S_RD1;
                    r_nxt.mem_addr = {table_search_descriptor_in.base, hsh,
                                      r_r.grp, 3'h4};
                end
            end
            S_RD1: begin
                if (mem_ack_in) begin
                    r_nxt.w1 = mem_rdata_in;
                    // virtual page compared against the descriptor
                    if (p0.v && p0.vsid == sg.vsid &&
                        p0.api == pi[ATU_PI_W-1 -: ATU_API_W]) begin
                        // referenced and changed bits written back
                        if (!p1.r || (is_store && !p1.c)) begin
                            p1.r = 1'b1;
                            p1.c = p1.c | is_store;
                            r_nxt.w1 = p1;
                            r_nxt.mem_we = 1'b1;
                            r_nxt.mem_wdata = p1;
                            r_nxt.st = S_MARK;
                        end else begin
                            r_nxt.mem_req = 1'b0;
                            r_nxt.st = S_FILL;
                        end
                    end else if (r_r.grp == ATU_GRP_LAST) begin
                        // page fault after a full group
                        r_nxt.mem_req = 1'b0;
                        r_nxt.resp.valid = 1'b1;
                        r_nxt.resp.pa = r_r.req.la;
                        r_nxt.resp.fault = 1'b1;
                        r_nxt.resp.io = 1'b0;
                        r_nxt.st = S_IDLE;
                        r_nxt.ready = 1'b1;
                    end else begin
                        r_nxt.grp = r_r.grp + ATU_GRP_W'(1);
                        r_nxt.st = S_RD0;
                        r_nxt.mem_addr = {table_search_descriptor_in.base,
                            hsh, r_r.grp + ATU_GRP_W'(1), 3'h0};
                    end
                end
            end
            S_MARK: begin
                if (mem_ack_in) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.mem_we = 1'b0;
                    r_nxt.st = S_FILL;
                end
            end
            S_FILL: begin
                p1 = atu_pd1_t'(r_r.w1);
                r_nxt.ub[{set, r_r.ub_lru[set]}] = {1'b1, sg.vsid,
                    pi[ATU_PI_W-1:ATU_SET_W], p1.ppn, p1.pp};
                r_nxt.st = S_LOOK;
            end
        endcase
        // Flush only between requests, so a walk never loses its fill
        if (flush_in && r_r.st == S_IDLE) begin
            for (int i = 0; i < ATU_UB_N; i++) r_nxt.ub[i].v = 1'b0;
            for (int i = 0; i < ATU_FB_N; i++) r_nxt.fb[i].v = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Special register port; user-level accesses are dropped
    atu_regs_t r_spr;
    always_comb begin
        atu_bx_t be;
        r_spr = r_nxt;
        be = r_r.bx[spr_addr_in.ent];
        r_spr.spr_rdata = '0;
        if (spr_sup_in) begin
            if (!spr_addr_in.blk) begin
                r_spr.spr_rdata = r_r.seg[{spr_addr_in.hi, spr_addr_in.ent,
                                           spr_addr_in.lo}];
                if (spr_wr_in) begin
                    r_spr.seg[{spr_addr_in.hi, spr_addr_in.ent,
                               spr_addr_in.lo}] = spr_wdata_in;
                end
            end else begin
                r_spr.spr_rdata = spr_addr_in.lo ? be.lo : be.hi;
                if (spr_wr_in && spr_addr_in.lo) begin
                    r_spr.bx[spr_addr_in.ent].lo = spr_wdata_in;
                end else if (spr_wr_in) begin
                    r_spr.bx[spr_addr_in.ent].hi = spr_wdata_in;
                end
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            r_r <= '0;
            r_r.st <= S_IDLE;
            r_r.ready <= 1'b1;
            r_r.fb_age <= ATU_FB_AGE_RST;
        end else begin
            r_r <= r_spr;
        end
    end

    assign ready_out = r_r.ready;
    assign resp_out = r_r.resp;
    assign spr_rdata_out = r_r.spr_rdata;
    assign mem_req_out = r_r.mem_req;
    assign mem_we_out = r_r.mem_we;
    assign mem_addr_out = r_r.mem_addr;
    assign mem_wdata_out = r_r.mem_wdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_accept;
        r_r.st == S_IDLE && req_valid_in;
    endsequence
    sequence s_miss;
        r_r.st == S_LOOK && look_walk;
    endsequence
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    accept_to_look_a: assert property (s_accept |=> r_r.st == S_LOOK && !ready_out)
        else $error("accepted request did not enter lookup");
    hit_answer_a: assert property (r_r.st == S_LOOK && !look_walk |=> resp_out.valid ##1 !resp_out.valid)
        else $error("hit answer not one cycle after lookup");
    offset_pass_a: assert property (resp_out.valid |-> resp_out.pa[ATU_PG_LO-1:0] == r_r.req.la[ATU_PG_LO-1:0])
        else $error("page offset altered");
    direct_map_a: assert property (r_r.st == S_LOOK && look_direct |=> resp_out.pa == r_r.req.la && !resp_out.fault)
        else $error("direct translation changed address");
    block_offset_a: assert property (r_r.st == S_LOOK && look_blk |=> resp_out.pa[ATU_BLK_LO-1:0] == r_r.req.la[ATU_BLK_LO-1:0])
        else $error("block offset altered");
    walk_start_a: assert property (s_miss |=> r_r.st == S_RD0 && mem_req_out && !mem_we_out)
        else $error("miss did not start table read");
    seg_guard_a: assert property (spr_wr_in && !spr_sup_in |=> $stable(r_r.seg) && $stable(r_r.bx))
        else $error("user write changed protected registers");
    fill_return_a: assert property (r_r.st == S_FILL |=> r_r.st == S_LOOK ##1 resp_out.valid)
        else $error("refill not followed by answer");

endmodule : atu_top

// File: tb/atu_mem_model.sv
// Page table memory model answering the translation walk
`timescale 1ns/10ps
module atu_mem_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] mem_wdata_in,
    output logic mem_ack_out,
    output logic [31:0] mem_rdata_out,
    input wire logic [31:0] hit_addr_in,
    input wire logic [31:0] word0_in,
    input wire logic [31:0] word1_in,
    input wire logic [3:0] delay_in,
    output logic [31:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [7:0] wr_cnt_out,
    output logic [7:0] rd_cnt_out
);
    logic [3:0] wait_r;
    logic [31:0] last_r;

    // Outside the ack cycle the bus shows the inverse, never a stale word
    assign mem_rdata_out = mem_ack_out ? last_r : ~last_r;

    // Ack after delay_in idle cycles; every other address reads invalid
    always @(posedge clk_in) begin
        mem_ack_out <= 1'b0;
        if (!reset_n_in) begin
            wait_r <= 4'h0;
            last_r <= 32'h0;
            wr_cnt_out <= 8'h00;
            rd_cnt_out <= 8'h00;
        end else if (mem_req_in && !mem_ack_out) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= delay_in) begin
                wait_r <= 4'h0;
                mem_ack_out <= 1'b1;
                if (mem_we_in) begin
                    wr_addr_out <= mem_addr_in;
                    wr_data_out <= mem_wdata_in;
                    wr_cnt_out <= wr_cnt_out + 8'h01;
                end else begin
                    rd_cnt_out <= rd_cnt_out + 8'h01;
                    last_r <= (mem_addr_in == hit_addr_in) ? word0_in :
                        (mem_addr_in == hit_addr_in + 32'h4) ? word1_in :
                        32'h0;
                end
            end
        end
    end
endmodule : atu_mem_model

// File: tb/tb_address_translation_unit.sv
// Self-checking bench of the address translation unit
`timescale 1ns/10ps
module tb_address_translation_unit import atu_pkg::*; ;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic req_valid_in = 1'b0, flush_in = 1'b0;
    logic spr_wr_in = 1'b0, spr_sup_in = 1'b0;
    atu_req_t req_in = '0;
    atu_tsd_t tsd = '{base: 16'h0123, rsv: 16'h0000};
    atu_spr_a_t spr_addr_in = '0;
    logic [31:0] spr_wdata_in = 32'h0;
    logic ready_out, mem_req_out, mem_we_out, mem_ack_in;
    atu_resp_t resp_out;
    logic [31:0] spr_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic [31:0] hit_addr = 32'h0, word0 = 32'h0, word1 = 32'h0;
    logic [31:0] wr_addr, wr_data;
    logic [3:0] delay = 4'h0;
    logic [7:0] wr_cnt, rd_cnt;
    int fails = 0, total_checks = 0, cyc = 0;

    atu_top atu_top_inst (.clk_in, .reset_n_in, .req_valid_in, .req_in,
        .ready_out, .resp_out, .flush_in, .table_search_descriptor_in(tsd),
        .spr_wr_in, .spr_sup_in, .spr_addr_in, .spr_wdata_in,
        .spr_rdata_out, .mem_req_out, .mem_we_out, .mem_addr_out,
        .mem_wdata_out, .mem_ack_in, .mem_rdata_in);
    atu_mem_model atu_mem_model_inst (.clk_in, .reset_n_in,
        .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
        .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in),
        .hit_addr_in(hit_addr), .word0_in(word0), .word1_in(word1),
        .delay_in(delay), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .wr_cnt_out(wr_cnt), .rd_cnt_out(rd_cnt));

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    // One request; lat counts negedges from the take edge to valid
    task automatic xlate(input logic [31:0] la, input atu_kind_t kind,
        input logic sup, input logic ien, input logic den, output int lat);
        lat = 0;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_in <= '{la: la, kind: kind, sup: sup, ien: ien, den: den};
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        do begin
            @(negedge clk_in);
            lat++;
        end while (resp_out.valid !== 1'b1 && lat < 300);
        if (resp_out.valid !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: no answer to request", $time);
        end
    endtask : xlate

    task automatic spr_put(input atu_spr_a_t a, input logic [31:0] d,
        input logic sup);
        @(posedge clk_in);
        spr_wr_in <= 1'b1;
        spr_sup_in <= sup;
        spr_addr_in <= a;
        spr_wdata_in <= d;
        @(posedge clk_in);
        spr_wr_in <= 1'b0;
    endtask : spr_put

    task automatic spr_get(input atu_spr_a_t a, input logic [31:0] exp);
        @(posedge clk_in);
        spr_sup_in <= 1'b1;
        spr_addr_in <= a;
        @(posedge clk_in);
        @(negedge clk_in);
        chk(spr_rdata_out, exp, "register read back");
    endtask : spr_get

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_direct();
        int lat;
        @(negedge clk_in);
        chk({29'h0, ready_out, resp_out.valid, mem_req_out}, 32'h4, "rst");
        xlate(32'hDEAD_BEEF, K_FETCH, 1'b1, 1'b0, 1'b0, lat);
        chk(lat, 2, "direct latency");
        chk(resp_out.pa, 32'hDEAD_BEEF, "direct fetch");
        xlate(32'h1234_5678, K_STORE, 1'b0, 1'b0, 1'b0, lat);
        chk(resp_out.pa, 32'h1234_5678, "direct store");
        chk({resp_out.fault, resp_out.io}, 2'h0, "direct flags");
        @(negedge clk_in);
        chk(resp_out.pa, 32'h1234_5678, "answer stands");
        $display("test direct done");
    endtask : t_direct

    task automatic t_regs();
        spr_put('{1'b0, 1'b0, 2'h1, 1'b1}, 32'h0000_0155, 1'b1);
        spr_put('{1'b0, 1'b0, 2'h1, 1'b1}, 32'hFFFF_FFFF, 1'b0);
        spr_get('{1'b0, 1'b0, 2'h1, 1'b1}, 32'h0000_0155);
        spr_put('{1'b1, 1'b0, 2'h1, 1'b0}, 32'h5000_0000, 1'b1);
        spr_put('{1'b1, 1'b0, 2'h1, 1'b1}, 32'h7000_0062, 1'b1);
        spr_get('{1'b1, 1'b0, 2'h1, 1'b0}, 32'h5000_0000);
        spr_get('{1'b1, 1'b0, 2'h1, 1'b1}, 32'h7000_0062);
        $display("test registers done");
    endtask : t_regs

    task automatic t_block();
        int lat;
        xlate(32'h5001_2345, K_LOAD, 1'b1, 1'b0, 1'b1, lat);
        chk(resp_out.pa, 32'h7001_2345, "block 128K");
        chk(lat, 2, "block latency");
        spr_put('{1'b1, 1'b0, 2'h1, 1'b0}, 32'h5000_003F, 1'b1);
        xlate(32'h507F_FFFC, K_STORE, 1'b1, 1'b0, 1'b1, lat);
        chk(resp_out.pa, 32'h707F_FFFC, "block 8M");
        chk(resp_out.fault, 1'b0, "block store");
        spr_put('{1'b1, 1'b0, 2'h1, 1'b1}, 32'h7000_0063, 1'b1);
        xlate(32'h507F_FFFC, K_STORE, 1'b1, 1'b0, 1'b1, lat);
        chk(resp_out.fault, 1'b1, "block read only");
        $display("test block done");
    endtask : t_block

    task automatic t_io();
        int lat;
        spr_put('{1'b0, 1'b1, 2'h0, 1'b1}, 32'h8000_0000, 1'b1);
        xlate(32'h9000_0010, K_LOAD, 1'b1, 1'b0, 1'b0, lat);
        chk(resp_out.io, 1'b1, "io flag");
        chk(resp_out.pa, 32'h9000_0010, "io address");
        xlate(32'h9000_0010, K_FETCH, 1'b1, 1'b1, 1'b0, lat);
        chk(resp_out.fault, 1'b1, "fetch to io segment");
        $display("test io done");
    endtask : t_io

    task automatic t_walk();
        logic [31:0] la;
        int lat;
        int rd0;
        la = 32'h3012_3ABC;
        hit_addr <= {16'h0123, 10'h155 ^ la[21:12], 3'h2, 3'h0};
        word0 <= {1'b1, 24'h000155, la[27:22], 1'b0};
        word1 <= 32'hABCD_E002;
        delay <= 4'h1;
        rd0 = rd_cnt;
        xlate(la, K_LOAD, 1'b0, 1'b0, 1'b1, lat);
        chk(resp_out.pa, 32'hABCD_EABC, "walk address");
        chk(rd_cnt - rd0, 6, "walk reads");
        chk(wr_cnt, 8'h01, "one status write");
        chk(wr_addr, hit_addr + 32'h4, "status address");
        chk(wr_data, 32'hABCD_E102, "status write");
        rd0 = rd_cnt;
        xlate(la, K_FETCH, 1'b0, 1'b1, 1'b0, lat);
        chk(lat, 2, "unified hit");
        xlate(la + 32'h4, K_FETCH, 1'b0, 1'b1, 1'b0, lat);
        chk(resp_out.pa, 32'hABCD_EAC0, "fetch buffer");
        chk(rd_cnt - rd0, 0, "no walk on hits");
        @(posedge clk_in);
        flush_in <= 1'b1;
        delay <= 4'h3;
        @(posedge clk_in);
        flush_in <= 1'b0;
        xlate(la, K_LOAD, 1'b0, 1'b0, 1'b1, lat);
        chk(rd_cnt - rd0, 6, "walk after flush");
        chk(resp_out.pa, 32'hABCD_EABC, "slow walk");
        $display("test walk done");
    endtask : t_walk

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////
    // Clock, hang guard and main sequence
    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("mismatch at %0t: run timed out", $time);
            conclude();
        end
    end

    initial begin
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_direct();
        t_regs();
        t_block();
        t_io();
        t_walk();
        conclude();
    end
endmodule : tb_address_translation_unit
